// file: shared/pst_map.svh
`ifndef PST_MAP_SVH
`define PST_MAP_SVH

// ==========================================================
// command codes
`define PST_CMD_ON_WAIT 8'h60
`define PST_CMD_RAMP 8'h61
`define PST_CMD_OFF_WAIT 8'h64
`define PST_CMD_STAT_BYTE 8'h78
`define PST_CMD_STAT_CML 8'h7e

// ==========================================================
// timing word layout
`define PST_EXP_MSB 15
`define PST_EXP_LSB 11
`define PST_EXP_VAL 5'h1f
`define PST_ON_FIXED 13'h1f00
`define PST_RAMP_FIXED 10'h03e0
`define PST_OFF_FIXED 13'h1f00
`define PST_ON_RESET 3'h0
`define PST_RAMP_RESET 6'h00
`define PST_OFF_RESET 3'h0

// ==========================================================
// status bits
`define PST_SB_CML_BIT 1
`define PST_CML_IVD_BIT 6
`define PST_CML_CMD_BIT 7

// ==========================================================
// timing: base tick is the 50 us minimum delay
`define PST_CLK_PERIOD_NS 25
`define PST_MIN_DELAY_NS 50000
`define PST_TICK_CYCLES ((`PST_MIN_DELAY_NS + `PST_CLK_PERIOD_NS - 1) / `PST_CLK_PERIOD_NS)
`define PST_HALF_MS_NS 500000
`define PST_TICKS_PER_HALF_MS (`PST_HALF_MS_NS / `PST_MIN_DELAY_NS)

`endif

// file: shared/pst_pkg.sv
package pst_pkg;

    typedef enum logic [2:0] {
        PST_IDLE,
        PST_ON_WAIT,
        PST_RAMP,
        PST_ON,
        PST_OFF_WAIT
    } pst_state_t;

    typedef struct packed {
        logic [2:0] onCode;
        logic [5:0] rampCode;
        logic [2:0] offCode;
        logic invalidData;
        logic invalidCmd;
        logic cmlSummary;
        pst_state_t seq;
        logic [15:0] divCnt;
        logic [8:0] tickCnt;
        logic [8:0] target;
        logic outputRiseEn;
        logic rampActive;
        logic inRegulation;
        logic softStopGo;
        logic [5:0] rampApplied;
        logic rspValid;
        logic rspNack;
        logic [15:0] rspData;
    } pst_regs_t;

endpackage

// file: verilog/pst_sequencer.sv
`timescale 1ns/100ps
`include "pst_map.svh"

module pst_sequencer
    import pst_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `PST_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdWrData,
    input wire logic loadDefaults,
    input wire logic [2:0] nvmOnCode,
    input wire logic [5:0] nvmRampCode,
    input wire logic [2:0] nvmOffCode,
    input wire logic useStrap,
    input wire logic [5:0] strapRampCode,
    input wire logic startCond,
    input wire logic stopCond,
    input wire logic bootFromSetpoint,
    input wire logic regulationReached,
    output logic rspValid,
    output logic rspNack,
    output logic [15:0] rspData,
    output logic cmlSummary,
    output logic outputRiseEn,
    output logic rampActive,
    output logic inRegulation,
    output logic softStopGo,
    output logic [5:0] rampApplied
);

    // ==========================================================
    // code maps, in 50 us ticks
    function automatic logic [8:0] onTicks(input logic [2:0] c);
        case (c)
            3'h0: onTicks = 9'd1;
            3'h1: onTicks = 9'(`PST_TICKS_PER_HALF_MS);
            3'h2: onTicks = 9'(2 * `PST_TICKS_PER_HALF_MS);
            default: onTicks = 9'(4 * `PST_TICKS_PER_HALF_MS);
        endcase
    endfunction

    // the printed table overlaps at code 3; the 1.5 ms row is taken
    function automatic logic [8:0] offTicks(input logic [2:0] c);
        case (c)
            3'h0: offTicks = 9'd0;
            3'h1, 3'h2: offTicks = 9'(2 * `PST_TICKS_PER_HALF_MS);
            3'h3: offTicks = 9'(3 * `PST_TICKS_PER_HALF_MS);
            default: offTicks = 9'(4 * `PST_TICKS_PER_HALF_MS);
        endcase
    endfunction

    // canonical codes: the lower bound of each supported range
    function automatic logic [2:0] onCanon(input logic [2:0] c);
        onCanon = (c >= 3'h3) ? 3'h3 : c;
    endfunction

    function automatic logic [5:0] rampCanon(input logic [5:0] c);
        rampCanon = 6'h00;
        for (int b = 1; b < 6; b++) begin
            if (c[b]) begin
                rampCanon = 6'(1 << b);
            end
        end
    endfunction

    // each ramp range doubles, so its length follows from the canonical code
    function automatic logic [8:0] rampTicks(input logic [5:0] c);
        rampTicks = 9'(((c < 6'h02) ? 6'h01 : rampCanon(c)) * `PST_TICKS_PER_HALF_MS);
    endfunction

    function automatic logic [2:0] offCanon(input logic [2:0] c);
        case (c)
            3'h0: offCanon = 3'h0;
            3'h1, 3'h2: offCanon = 3'h1;
            3'h3: offCanon = 3'h3;
            default: offCanon = 3'h4;
        endcase
    endfunction

    // ==========================================================
    // state
    pst_regs_t st_reg;
    pst_regs_t st_next;
    logic tick;
    logic timerDone;
    logic badWrite;

    assign tick = (st_reg.divCnt == 16'(TICK_CYCLES - 1));
    assign timerDone = tick && (st_reg.tickCnt + 9'd1 >= st_reg.target);

    always_comb begin
        st_next = st_reg;
        badWrite = 1'b0;
        st_next.rspValid = 1'b0;
        st_next.rspNack = 1'b0;
        st_next.softStopGo = 1'b0;

        // ======================================================
        // command port
        if (cmdValid) begin
            st_next.rspValid = 1'b1;
            st_next.rspData = 16'h0000;
            if (cmdWrite) begin
                case (cmdCode)
                    `PST_CMD_ON_WAIT: begin
                        badWrite = (cmdWrData[15:3] != `PST_ON_FIXED);
                        if (!badWrite) begin
                            st_next.onCode = cmdWrData[2:0];
                        end
                    end
                    `PST_CMD_RAMP: begin
                        badWrite = (cmdWrData[15:6] != `PST_RAMP_FIXED);
                        if (!badWrite) begin
                            st_next.rampCode = cmdWrData[5:0];
                        end
                    end
                    `PST_CMD_OFF_WAIT: begin
                        badWrite = (cmdWrData[15:3] != `PST_OFF_FIXED);
                        if (!badWrite) begin
                            st_next.offCode = cmdWrData[2:0];
                        end
                    end
                    `PST_CMD_STAT_CML: begin
                        // write one to clear; the detail register is the only clear path
                        st_next.invalidData &= ~cmdWrData[`PST_CML_IVD_BIT];
                        st_next.invalidCmd &= ~cmdWrData[`PST_CML_CMD_BIT];
                    end
                    `PST_CMD_STAT_BYTE: badWrite = 1'b1;
                    default: begin
                        st_next.rspNack = 1'b1;
                        st_next.invalidCmd = 1'b1;
                    end
                endcase
            end else begin
                case (cmdCode)
                    `PST_CMD_ON_WAIT: st_next.rspData = {`PST_ON_FIXED, st_reg.onCode};
                    `PST_CMD_RAMP: st_next.rspData = {`PST_RAMP_FIXED, st_reg.rampCode};
                    `PST_CMD_OFF_WAIT: st_next.rspData = {`PST_OFF_FIXED, st_reg.offCode};
                    `PST_CMD_STAT_BYTE: begin
                        st_next.rspData[`PST_SB_CML_BIT] = st_reg.cmlSummary;
                    end
                    `PST_CMD_STAT_CML: begin
                        st_next.rspData[`PST_CML_IVD_BIT] = st_reg.invalidData;
                        st_next.rspData[`PST_CML_CMD_BIT] = st_reg.invalidCmd;
                    end
                    default: begin
                        st_next.rspNack = 1'b1;
                        st_next.invalidCmd = 1'b1;
                    end
                endcase
            end
            // setting the flag comes last so it wins over a clear
            if (badWrite) begin
                st_next.rspNack = 1'b1;
                st_next.invalidData = 1'b1;
            end
        end

        // defaults reload canonical codes, never the raw stored ones
        if (loadDefaults) begin
            st_next.onCode = onCanon(nvmOnCode);
            st_next.offCode = offCanon(nvmOffCode);
            st_next.rampCode = useStrap ? rampCanon(strapRampCode) : rampCanon(nvmRampCode);
        end

        st_next.cmlSummary = st_next.invalidData | st_next.invalidCmd;

        // ======================================================
        // tick divider and timer
        if (st_reg.seq == PST_ON_WAIT || st_reg.seq == PST_RAMP
                || st_reg.seq == PST_OFF_WAIT) begin
            st_next.divCnt = tick ? 16'h0000 : st_reg.divCnt + 16'h0001;
            if (tick) begin
                st_next.tickCnt = st_reg.tickCnt + 9'd1;
            end
        end

        // ======================================================
        // sequencer
        case (st_reg.seq)
            PST_IDLE: begin
                if (startCond) begin
                    st_next.seq = PST_ON_WAIT;
                    st_next.target = onTicks(st_reg.onCode);
                    st_next.divCnt = 16'h0000;
                    st_next.tickCnt = 9'd0;
                end
            end
            PST_ON_WAIT: begin
                if (stopCond) begin
                    st_next.seq = PST_IDLE;
                end else if (timerDone) begin
                    st_next.seq = PST_RAMP;
                    st_next.outputRiseEn = 1'b1;
                    st_next.rampActive = 1'b1;
                    st_next.target = rampTicks(st_reg.rampCode);
                    st_next.rampApplied = rampCanon(st_reg.rampCode);
                    st_next.divCnt = 16'h0000;
                    st_next.tickCnt = 9'd0;
                end
            end
            PST_RAMP: begin
                // a setpoint boot ends on regulation or on the selected time, whichever comes first
                if (timerDone || (bootFromSetpoint && regulationReached)) begin
                    st_next.seq = PST_ON;
                    st_next.rampActive = 1'b0;
                    st_next.inRegulation = 1'b1;
                end
                if (stopCond) begin
                    st_next.seq = PST_ON;
                    st_next.rampActive = 1'b0;
                end
            end
            PST_ON: begin
                if (stopCond) begin
                    st_next.inRegulation = 1'b0;
                    if (offTicks(st_reg.offCode) == 9'd0) begin
                        st_next.seq = PST_IDLE;
                        st_next.softStopGo = 1'b1;
                        st_next.outputRiseEn = 1'b0;
                    end else begin
                        st_next.seq = PST_OFF_WAIT;
                        st_next.target = offTicks(st_reg.offCode);
                        st_next.divCnt = 16'h0000;
                        st_next.tickCnt = 9'd0;
                    end
                end
            end
            PST_OFF_WAIT: begin
                if (timerDone) begin
                    st_next.seq = PST_IDLE;
                    st_next.softStopGo = 1'b1;
                    st_next.outputRiseEn = 1'b0;
                end
            end
            default: st_next.seq = PST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_reg <= '{onCode: `PST_ON_RESET, rampCode: `PST_RAMP_RESET,
                        offCode: `PST_OFF_RESET, seq: PST_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign rspValid = st_reg.rspValid;
    assign rspNack = st_reg.rspNack;
    assign rspData = st_reg.rspData;
    assign cmlSummary = st_reg.cmlSummary;
    assign outputRiseEn = st_reg.outputRiseEn;
    assign rampActive = st_reg.rampActive;
    assign inRegulation = st_reg.inRegulation;
    assign softStopGo = st_reg.softStopGo;
    assign rampApplied = st_reg.rampApplied;

    // ==========================================================
    // checks
    logic [15:0] waitCycles;

    always_ff @(posedge clock) begin
        if (!rst_n || st_reg.seq != PST_ON_WAIT) begin
            waitCycles <= 16'h0000;
        end else if (waitCycles != 16'hffff) begin
            waitCycles <= waitCycles + 16'h0001;
        end
    end

    sequence s_badWrite(logic [7:0] code, logic badHigh);
        cmdValid && cmdWrite && cmdCode == code && badHigh && !loadDefaults;
    endsequence

    sequence s_nackFlag;
        rspValid && rspNack && cmlSummary;
    endsequence

    property p_min_delay;
        @(posedge clock) disable iff (!rst_n)
        $rose(rampActive) |-> waitCycles >= 16'(TICK_CYCLES - 1);
    endproperty
    a_min_delay: assert property (p_min_delay) else $error("ramp began before 50 us");

    property p_on_bad;
        @(posedge clock) disable iff (!rst_n)
        s_badWrite(`PST_CMD_ON_WAIT, cmdWrData[15:3] != `PST_ON_FIXED)
            |=> s_nackFlag ##0 $stable(st_reg.onCode);
    endproperty
    a_on_bad: assert property (p_on_bad) else $error("bad turn-on write not refused");

    property p_ramp_bad;
        @(posedge clock) disable iff (!rst_n)
        s_badWrite(`PST_CMD_RAMP, cmdWrData[15:6] != `PST_RAMP_FIXED)
            |=> s_nackFlag ##0 $stable(st_reg.rampCode);
    endproperty
    a_ramp_bad: assert property (p_ramp_bad) else $error("bad ramp write not refused");

    property p_off_bad;
        @(posedge clock) disable iff (!rst_n)
        s_badWrite(`PST_CMD_OFF_WAIT, cmdWrData[15:3] != `PST_OFF_FIXED)
            |=> s_nackFlag ##0 $stable(st_reg.offCode);
    endproperty
    a_off_bad: assert property (p_off_bad) else $error("bad turn-off write not refused");

    property p_store;
        @(posedge clock) disable iff (!rst_n)
        cmdValid && cmdWrite && cmdCode == `PST_CMD_RAMP
            && cmdWrData[15:6] == `PST_RAMP_FIXED && !loadDefaults
            |=> st_reg.rampCode == $past(cmdWrData[5:0]) && !rspNack;
    endproperty
    a_store: assert property (p_store) else $error("ramp code not stored as written");

    property p_exponent;
        @(posedge clock) disable iff (!rst_n)
        cmdValid && !cmdWrite && cmdCode[7:4] == 4'h6 && !(cmdCode[3:0] inside {4'h2, 4'h3})
            && cmdCode[3:0] <= 4'h4
            |=> rspData[`PST_EXP_MSB:`PST_EXP_LSB] == `PST_EXP_VAL && rspData[10:6] == 5'h00;
    endproperty
    a_exponent: assert property (p_exponent) else $error("exponent or reserved bits wrong");

    property p_summary;
        @(posedge clock) disable iff (!rst_n)
        cmlSummary == (st_reg.invalidData || st_reg.invalidCmd);
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit not a mirror");

    property p_stop_wait;
        @(posedge clock) disable iff (!rst_n)
        st_reg.seq == PST_ON && stopCond && st_reg.offCode != 3'h0
            |=> !softStopGo ##1 !softStopGo;
    endproperty
    a_stop_wait: assert property (p_stop_wait) else $error("soft stop without delay");

    property p_no_rise_idle;
        @(posedge clock) disable iff (!rst_n)
        $rose(outputRiseEn) |-> $past(st_reg.seq) == PST_ON_WAIT;
    endproperty
    a_no_rise_idle: assert property (p_no_rise_idle) else $error("rise without turn-on wait");

endmodule // pst_sequencer

// file: tb/pst_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// host side of the command port: one word request at a time
module pst_host_model (
    input wire logic clock,
    output logic cmdValid,
    output logic cmdWrite,
    output logic [7:0] cmdCode,
    output logic [15:0] cmdWrData,
    input wire logic rspValid,
    input wire logic rspNack,
    input wire logic [15:0] rspData
);
    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdCode = 8'h00;
        cmdWrData = 16'h0000;
    end

    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic nack, output logic [15:0] rdata, output logic seen);
        int n;
        @(posedge clock);
        cmdValid <= 1'b1;
        cmdWrite <= wr;
        cmdCode <= code;
        cmdWrData <= data;
        @(posedge clock);
        cmdValid <= 1'b0;
        // released lines show the inverse, so a stale value never looks valid
        cmdWrite <= ~wr;
        cmdCode <= ~code;
        cmdWrData <= ~data;
        #1;
        n = 0;
        while (rspValid !== 1'b1 && n < 4) begin
            @(posedge clock);
            #1;
            n++;
        end
        seen = (rspValid === 1'b1);
        nack = rspNack;
        rdata = rspData;
    endtask
endmodule // pst_host_model

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    import pst_pkg::*;
    localparam int T = 4;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cmdValid, cmdWrite, rspValid, rspNack, cmlSummary;
    logic [7:0] cmdCode;
    logic [15:0] cmdWrData, rspData;
    logic loadDefaults = 1'b0, useStrap = 1'b0, startCond = 1'b0, stopCond = 1'b0;
    logic bootFromSetpoint = 1'b0, regulationReached = 1'b0;
    logic [2:0] nvmOnCode = 3'h0, nvmOffCode = 3'h0;
    logic [5:0] nvmRampCode = 6'h00, strapRampCode = 6'h00, rampApplied;
    logic outputRiseEn, rampActive, inRegulation, softStopGo;
    int err_count = 0;
    int checks = 0;
    int n;
    // cases: turn-on, ramp and turn-off codes with their lengths in ticks
    int onCode[4] = '{0, 1, 2, 6};
    int onTk[4] = '{1, 10, 20, 40};
    int rampCode[4] = '{1, 3, 12, 40};
    int rampCanon[4] = '{0, 2, 8, 32};
    int rampTk[4] = '{10, 20, 80, 320};
    int offCode[4] = '{0, 2, 3, 7};
    int offTk[4] = '{0, 20, 30, 40};

    always #12.5 clock = ~clock;

    pst_host_model host (.clock(clock), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
        .cmdCode(cmdCode), .cmdWrData(cmdWrData), .rspValid(rspValid),
        .rspNack(rspNack), .rspData(rspData));

    pst_sequencer #(.TICK_CYCLES(T)) dut (.clock(clock), .rst_n(rst_n),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
        .cmdWrData(cmdWrData), .loadDefaults(loadDefaults), .nvmOnCode(nvmOnCode),
        .nvmRampCode(nvmRampCode), .nvmOffCode(nvmOffCode), .useStrap(useStrap),
        .strapRampCode(strapRampCode), .startCond(startCond), .stopCond(stopCond),
        .bootFromSetpoint(bootFromSetpoint), .regulationReached(regulationReached),
        .rspValid(rspValid), .rspNack(rspNack), .rspData(rspData),
        .cmlSummary(cmlSummary), .outputRiseEn(outputRiseEn), .rampActive(rampActive),
        .inRegulation(inRegulation), .softStopGo(softStopGo), .rampApplied(rampApplied));

    // ==========================================================
    // checking and closing
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // counts are allowed two cycles either way of the tick figure
    task automatic near(input string name, input int seen, input int exp);
        check(name, 16'((seen >= exp - 2 && seen <= exp + 2) ? exp : seen), 16'(exp));
    endtask

    // ==========================================================
    // command port and sequencer drivers
    task automatic wr(input logic [7:0] code, input logic [15:0] d, input logic expNack);
        logic nk;
        logic [15:0] rdat;
        logic sn;
        host.xfer(1'b1, code, d, nk, rdat, sn);
        check("write answer", {15'h0000, sn}, 16'h0001);
        check("write nack", {15'h0000, nk}, {15'h0000, expNack});
    endtask

    task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic expNack);
        logic nk;
        logic [15:0] d;
        logic sn;
        host.xfer(1'b0, code, 16'h0000, nk, d, sn);
        check("read answer", {15'h0000, sn}, 16'h0001);
        check("read nack", {15'h0000, nk}, {15'h0000, expNack});
        if (!expNack) begin
            check("read data", d, exp);
        end
    endtask

    task automatic pulse(input logic isStop);
        @(posedge clock);
        startCond <= ~isStop;
        stopCond <= isStop;
        @(posedge clock);
        startCond <= 1'b0;
        stopCond <= 1'b0;
        #1;
    endtask

    task automatic measure(input int which, output int cnt);
        logic hit;
        cnt = 0;
        hit = 1'b0;
        while (cnt < 2000) begin
            hit = (which == 0) ? outputRiseEn : (which == 1) ? inRegulation : softStopGo;
            if (hit === 1'b1) begin
                break;
            end
            @(posedge clock);
            #1;
            cnt++;
        end
    endtask

    // ==========================================================
    // tests
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check("summary after reset", {15'h0000, cmlSummary}, 16'h0000);
        check("rise after reset", {15'h0000, outputRiseEn}, 16'h0000);
        rd(8'h60, 16'hf800, 1'b0);
        rd(8'h61, 16'hf800, 1'b0);
        rd(8'h64, 16'hf800, 1'b0);
        wr(8'h60, 16'hf807, 1'b0);
        rd(8'h60, 16'hf807, 1'b0);
        wr(8'h61, 16'hf83f, 1'b0);
        rd(8'h61, 16'hf83f, 1'b0);
        wr(8'h64, 16'hf805, 1'b0);
        rd(8'h64, 16'hf805, 1'b0);
        // read-only parts of each word: refused and discarded
        wr(8'h60, 16'hf808, 1'b1);
        check("summary set", {15'h0000, cmlSummary}, 16'h0001);
        rd(8'h60, 16'hf807, 1'b0);
        rd(8'h78, 16'h0002, 1'b0);
        rd(8'h7e, 16'h0040, 1'b0);
        wr(8'h61, 16'hf840, 1'b1);
        rd(8'h61, 16'hf83f, 1'b0);
        wr(8'h64, 16'h7805, 1'b1);
        rd(8'h64, 16'hf805, 1'b0);
        wr(8'h78, 16'h0000, 1'b1);
        rd(8'h20, 16'h0000, 1'b1);
        rd(8'h7e, 16'h00c0, 1'b0);
        wr(8'h7e, 16'h00c0, 1'b0);
        check("summary cleared", {15'h0000, cmlSummary}, 16'h0000);
        rd(8'h78, 16'h0000, 1'b0);
        // restore from storage and from the strap
        @(posedge clock);
        nvmOnCode <= 3'h5;
        nvmRampCode <= 6'h0d;
        nvmOffCode <= 3'h2;
        loadDefaults <= 1'b1;
        @(posedge clock);
        loadDefaults <= 1'b0;
        rd(8'h60, 16'hf803, 1'b0);
        rd(8'h61, 16'hf808, 1'b0);
        rd(8'h64, 16'hf801, 1'b0);
        @(posedge clock);
        useStrap <= 1'b1;
        strapRampCode <= 6'h21;
        loadDefaults <= 1'b1;
        @(posedge clock);
        loadDefaults <= 1'b0;
        useStrap <= 1'b0;
        rd(8'h61, 16'hf820, 1'b0);
        // full start, ramp and stop for each case
        for (int i = 0; i < 4; i++) begin
            wr(8'h60, 16'hf800 | 16'(onCode[i]), 1'b0);
            wr(8'h61, 16'hf800 | 16'(rampCode[i]), 1'b0);
            wr(8'h64, 16'hf800 | 16'(offCode[i]), 1'b0);
            pulse(1'b0);
            measure(0, n);
            near("turn-on delay", n, onTk[i] * T);
            check("ramp active", {15'h0000, rampActive}, 16'h0001);
            check("ramp applied", {10'h000, rampApplied}, 16'(rampCanon[i]));
            measure(1, n);
            near("ramp time", n, rampTk[i] * T);
            check("ramp ended", {15'h0000, rampActive}, 16'h0000);
            pulse(1'b1);
            measure(2, n);
            near("turn-off delay", n, offTk[i] * T);
            @(posedge clock);
            #1;
            check("output dropped", {15'h0000, outputRiseEn}, 16'h0000);
        end
        // stop in the turn-on wait drops the start; stop in the ramp keeps the output
        pulse(1'b0);
        pulse(1'b1);
        measure(0, n);
        check("aborted start", 16'(n), 16'h07d0);
        pulse(1'b0);
        wr(8'h60, 16'hf800, 1'b0);
        measure(0, n);
        near("latched turn-on", n + 2, 40 * T);
        pulse(1'b1);
        check("ramp stopped", {14'h0000, rampActive, inRegulation}, 16'h0000);
        check("output held", {15'h0000, outputRiseEn}, 16'h0001);
        pulse(1'b1);
        measure(2, n);
        near("turn-off after ramp stop", n, 40 * T);
        // setpoint boot: regulation cuts the ramp short
        @(posedge clock);
        bootFromSetpoint <= 1'b1;
        regulationReached <= 1'b1;
        pulse(1'b0);
        measure(0, n);
        measure(1, n);
        check("setpoint ramp short", 16'(n < 8), 16'h0001);
        pulse(1'b1);
        measure(2, n);
        near("turn-off after setpoint", n, 40 * T);
        summarize();
    end

    initial begin
        #(1_000_000);
        err_count++;
        summarize();
    end
endmodule // testbench
